// file: logic/crac_async_bit.sv
`timescale 1ns/1ns
// Storage bit with active-low clear and preset; clear wins when both act
module crac_async_bit
(
  input  wire logic               clk,
  input  wire crac_pkg::crac_async_s ctl,
  input  wire logic               d,
  output logic                    q
);

  logic prsEffN;

  // Preset is masked while clear acts, so a clear released under a held preset
  // gives a fresh preset edge instead of leaving the bit stuck at zero
  assign prsEffN = ctl.prsN | ~ctl.clrN;

  always_ff @(posedge clk or negedge ctl.clrN or negedge prsEffN)
  begin
    if (!ctl.clrN)
      q <= 1'b0;
    else if (!prsEffN)
      q <= 1'b1;
    else
      q <= d;
  end

endmodule

// file: logic/crac_cell_ctrl.sv
`timescale 1ns/1ns
module crac_cell_ctrl
(
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [crac_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [crac_pkg::NUM_DED-1:0] dedIn,
  input  wire logic                         chipResetN,
  input  wire logic                         blockCtrlA,
  input  wire logic                         blockCtrlB,
  input  wire logic                         loadData,
  input  wire logic                         cellData,
  output logic                              storedBit,
  output logic      [crac_pkg::NUM_DED-1:0] dedData,
  input  wire logic                         pinIn,
  output logic                              pinOut,
  output logic                              pinOe,
  output logic                              pinCellData
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [crac_pkg::NUM_SYNC-1:0] syncRaw;
  logic [crac_pkg::NUM_SYNC-1:0] sync1_q;
  logic [crac_pkg::NUM_SYNC-1:0] sync2_q;
  logic [crac_pkg::NUM_SYNC-1:0] sync3_q;
  logic [crac_pkg::NUM_SYNC-1:0] filt_q;

  assign syncRaw = {chipResetN, pinIn, dedIn};

  // A change is taken only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < crac_pkg::NUM_SYNC; gi++)
    begin : g_sync
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          sync1_q[gi] <= crac_pkg::SYNC_RST[gi];
          sync2_q[gi] <= crac_pkg::SYNC_RST[gi];
          sync3_q[gi] <= crac_pkg::SYNC_RST[gi];
          filt_q[gi]  <= crac_pkg::SYNC_RST[gi];
        end
        else
        begin
          sync1_q[gi] <= syncRaw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi])
            filt_q[gi] <= sync3_q[gi];
        end
      end
    end
  endgenerate

  logic [crac_pkg::NUM_DED-1:0] dedSync;
  logic                         pinSync;
  logic                         chipRstSyncN;

  assign dedSync      = filt_q[crac_pkg::NUM_DED-1:0];
  assign pinSync      = filt_q[crac_pkg::NUM_DED];
  assign chipRstSyncN = filt_q[crac_pkg::NUM_DED+1];

  // ------------------------------------------------------------
  // Registers and APB slave
  // ------------------------------------------------------------
  crac_pkg::crac_cfg_s cfg_q;
  crac_pkg::crac_cfg_s cfg_d;
  logic [5:0]          sw_q;
  logic [5:0]          sw_d;
  logic [31:0]         prdata_q;
  logic [31:0]         prdata_d;
  logic                slvErr_q;

  logic hitCfg;
  logic hitSw;
  logic hitSt;
  logic hitAny;
  logic setup;
  logic wrCfg;
  logic wrSw;
  logic [31:0] statusWord;
  logic [31:0] cfgWord;

  assign hitCfg = (paddr == crac_pkg::OFF_CFG);
  assign hitSw  = (paddr == crac_pkg::OFF_SWCTRL);
  assign hitSt  = (paddr == crac_pkg::OFF_STATUS);
  assign hitAny = hitCfg | hitSw | hitSt;
  assign setup  = psel & ~penable;
  assign wrCfg  = psel & penable & pwrite & hitCfg;
  assign wrSw   = psel & penable & pwrite & hitSw;

  assign cfg_d.mode      = wrCfg ? crac_pkg::crac_mode_e'(pwdata[crac_pkg::CFG_MODE_LSB +: 2]) : cfg_q.mode;
  assign cfg_d.chipRstEn = wrCfg ? pwdata[crac_pkg::CFG_RSTEN_BIT] : cfg_q.chipRstEn;
  assign cfg_d.srcA      = wrCfg ? pwdata[crac_pkg::CFG_SRCA_LSB +: 3] : cfg_q.srcA;
  assign cfg_d.srcB      = wrCfg ? pwdata[crac_pkg::CFG_SRCB_LSB +: 3] : cfg_q.srcB;
  assign cfg_d.srcCe     = wrCfg ? pwdata[crac_pkg::CFG_SRCCE_LSB +: 3] : cfg_q.srcCe;
  assign cfg_d.pinMode   = wrCfg ? crac_pkg::crac_pin_e'(pwdata[crac_pkg::CFG_PINMODE_LSB +: 2]) : cfg_q.pinMode;
  assign cfg_d.srcOe     = wrCfg ? pwdata[crac_pkg::CFG_SRCOE_LSB +: 3] : cfg_q.srcOe;
  assign sw_d            = wrSw ? pwdata[5:0] : sw_q;

  assign cfgWord = {9'h000, cfg_q.srcOe, 2'b00, cfg_q.pinMode, 1'b0, cfg_q.srcCe, 1'b0, cfg_q.srcB,
                    1'b0, cfg_q.srcA, 1'b0, cfg_q.chipRstEn, cfg_q.mode};

  // Read data is captured in the setup cycle so the answer is a flop
  assign prdata_d = (!setup || pwrite) ? prdata_q :
                    hitCfg ? cfgWord :
                    hitSw  ? {26'h000_0000, sw_q} :
                    hitSt  ? statusWord : 32'h0000_0000;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_q    <= crac_pkg::CFG_RST;
      sw_q     <= crac_pkg::SWCTRL_RST;
      prdata_q <= 32'h0000_0000;
      slvErr_q <= 1'b0;
    end
    else
    begin
      cfg_q    <= cfg_d;
      sw_q     <= sw_d;
      prdata_q <= prdata_d;
      slvErr_q <= setup ? ~hitAny : slvErr_q;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & slvErr_q;

  // ------------------------------------------------------------
  // Control source selection
  // ------------------------------------------------------------
  // Code 0 takes the local line, 1..6 a dedicated input, 7 forces inactive
  function automatic logic pickSrc(input logic [2:0] sel, input logic localLine,
                                   input logic [crac_pkg::NUM_DED-1:0] ded);
    logic r;
    r = 1'b0;
    if (sel == crac_pkg::SRC_LOCAL)
      r = localLine;
    else if (sel != crac_pkg::SRC_OFF)
      r = ded[sel - 3'd1];
    return r;
  endfunction

  logic lineA;
  logic lineB;
  logic cellCe;
  logic swOe;

  assign lineA  = pickSrc(cfg_q.srcA, blockCtrlA | sw_q[crac_pkg::SW_LINEA_BIT], dedSync);
  assign lineB  = pickSrc(cfg_q.srcB, blockCtrlB | sw_q[crac_pkg::SW_LINEB_BIT], dedSync);
  assign cellCe = (cfg_q.srcCe == crac_pkg::SRC_LOCAL) ? 1'b1 : pickSrc(cfg_q.srcCe, 1'b1, dedSync);
  assign swOe   = sw_q[crac_pkg::SW_OE_BIT];

  assign dedData = dedSync;

  // ------------------------------------------------------------
  // Logic cell register clear and preset steering
  // ------------------------------------------------------------
  logic ldData;
  logic lpMode;
  logic chipClr;
  logic presetReq;
  logic clearReq;
  logic cellD;
  logic cellQ;
  crac_pkg::crac_async_s cellCtl;

  assign ldData  = loadData | sw_q[crac_pkg::SW_LOAD_BIT];
  assign lpMode  = (cfg_q.mode == crac_pkg::MODE_LOAD_PRESET);
  assign chipClr = cfg_q.chipRstEn & ~chipRstSyncN;

  always_comb
  begin
    presetReq = 1'b0;
    clearReq  = 1'b0;
    case (cfg_q.mode)
      crac_pkg::MODE_PRESET_CLEAR:
      begin
        presetReq = lineA;
        clearReq  = lineB;
      end
      crac_pkg::MODE_LOAD_CLEAR:
      begin
        presetReq = lineA & ldData;
        clearReq  = (lineA & ~ldData) | lineB;
      end
      crac_pkg::MODE_LOAD_PRESET:
      begin
        presetReq = lineA & ~ldData;
        clearReq  = (lineA & ldData) | lineB;
      end
      crac_pkg::MODE_LOAD_ONLY:
      begin
        presetReq = lineA & ldData;
        clearReq  = lineA & ~ldData;
      end
      default:
      begin
        presetReq = 1'b0;
        clearReq  = 1'b0;
      end
    endcase
  end

  assign cellCtl.prsN = ~presetReq;
  assign cellCtl.clrN = rstn & ~chipClr & ~clearReq;

  assign cellD = cellCe ? (lpMode ? ~(cellData ^ sw_q[crac_pkg::SW_DATA_BIT])
                                   : (cellData ^ sw_q[crac_pkg::SW_DATA_BIT]))
                        : cellQ;

  crac_async_bit u_cellBit
  (
    .clk (clk),
    .ctl (cellCtl),
    .d   (cellD),
    .q   (cellQ)
  );

  assign storedBit = lpMode ? ~cellQ : cellQ;

  // ------------------------------------------------------------
  // Pin cell
  // ------------------------------------------------------------
  logic pinD;
  logic pinQ;
  logic pinDrive;
  crac_pkg::crac_async_s pinCtl;

  assign pinD = (cfg_q.pinMode == crac_pkg::PIN_INPUT) ? pinSync : sw_q[crac_pkg::SW_PINOUT_BIT];

  assign pinCtl.prsN = 1'b1;
  assign pinCtl.clrN = rstn & ~chipClr;

  crac_async_bit u_pinBit
  (
    .clk (clk),
    .ctl (pinCtl),
    .d   (pinD),
    .q   (pinQ)
  );

  assign pinDrive = (cfg_q.pinMode == crac_pkg::PIN_OUTPUT) ? 1'b1 :
                    (cfg_q.pinMode == crac_pkg::PIN_BIDIR)  ? pickSrc(cfg_q.srcOe, swOe, dedSync) :
                    1'b0;

  assign pinOe       = pinDrive;
  assign pinOut      = pinQ;
  // Bidirectional input data is left unregistered for an adjacent logic cell
  assign pinCellData = (cfg_q.pinMode == crac_pkg::PIN_INPUT) ? pinQ : pinSync;

  // ------------------------------------------------------------
  // Status
  // ------------------------------------------------------------
  assign statusWord = {18'h0_0000, dedSync, 4'h0, ~chipRstSyncN, pinDrive, pinQ, storedBit};

endmodule

// file: logic/crac_pkg.sv
package crac_pkg;

  // ------------------------------------------------------------
  // Register map (APB, byte addresses)
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFF_CFG      = 8'h00;
  localparam logic [7:0]  OFF_SWCTRL   = 8'h04;
  localparam logic [7:0]  OFF_STATUS   = 8'h08;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  // CFG
  localparam int unsigned CFG_MODE_LSB    = 0;
  localparam int unsigned CFG_RSTEN_BIT   = 2;
  localparam int unsigned CFG_SRCA_LSB    = 4;
  localparam int unsigned CFG_SRCB_LSB    = 8;
  localparam int unsigned CFG_SRCCE_LSB   = 12;
  localparam int unsigned CFG_PINMODE_LSB = 16;
  localparam int unsigned CFG_SRCOE_LSB   = 20;
  // SWCTRL
  localparam int unsigned SW_LINEA_BIT    = 0;
  localparam int unsigned SW_LINEB_BIT    = 1;
  localparam int unsigned SW_LOAD_BIT     = 2;
  localparam int unsigned SW_DATA_BIT     = 3;
  localparam int unsigned SW_PINOUT_BIT   = 4;
  localparam int unsigned SW_OE_BIT       = 5;
  // STATUS
  localparam int unsigned ST_STORED_BIT   = 0;
  localparam int unsigned ST_PINREG_BIT   = 1;
  localparam int unsigned ST_PINOE_BIT    = 2;
  localparam int unsigned ST_CHIPRST_BIT  = 3;
  localparam int unsigned ST_DED_LSB      = 8;

  // ------------------------------------------------------------
  // Sizes and reset values
  // ------------------------------------------------------------
  localparam int unsigned NUM_DED         = 6;
  localparam int unsigned NUM_SYNC        = 8;
  // Dedicated inputs and pin reset low; chip reset pin idles high
  localparam logic [7:0]  SYNC_RST        = 8'h80;
  localparam logic [2:0]  SRC_LOCAL       = 3'h0;
  localparam logic [2:0]  SRC_OFF         = 3'h7;
  localparam logic [5:0]  SWCTRL_RST      = 6'h00;

  typedef enum logic [1:0]
  {
    MODE_PRESET_CLEAR = 2'b00,
    MODE_LOAD_CLEAR   = 2'b01,
    MODE_LOAD_PRESET  = 2'b10,
    MODE_LOAD_ONLY    = 2'b11
  } crac_mode_e;

  typedef enum logic [1:0]
  {
    PIN_INPUT  = 2'b00,
    PIN_OUTPUT = 2'b01,
    PIN_BIDIR  = 2'b10,
    PIN_UNUSED = 2'b11
  } crac_pin_e;

  typedef struct packed
  {
    crac_mode_e mode;
    logic       chipRstEn;
    logic [2:0] srcA;
    logic [2:0] srcB;
    logic [2:0] srcCe;
    crac_pin_e  pinMode;
    logic [2:0] srcOe;
  } crac_cfg_s;

  localparam crac_cfg_s CFG_RST = '{mode: MODE_PRESET_CLEAR, chipRstEn: 1'b1, srcA: 3'h0, srcB: 3'h0,
                                    srcCe: 3'h0, pinMode: PIN_INPUT, srcOe: 3'h0};

  typedef struct packed
  {
    logic prsN;
    logic clrN;
  } crac_async_s;

endpackage

// file: sim/crac_cell_checker.sv
`timescale 1ns/1ns
module crac_cell_checker
(
  input wire logic                         clk,
  input wire logic                         rstn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [crac_pkg::ADDR_W-1:0]  paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pslverr,
  input wire logic [crac_pkg::NUM_DED-1:0] dedIn,
  input wire logic                         chipResetN,
  input wire logic                         blockCtrlA,
  input wire logic                         blockCtrlB,
  input wire logic                         loadData,
  input wire logic                         storedBit,
  input wire logic [crac_pkg::NUM_DED-1:0] dedData,
  input wire logic                         pinOut,
  input wire logic                         pinOe
);
  // ------------------------------------------------------------
  // Shadow of the configuration, seen only through bus writes
  // ------------------------------------------------------------
  logic [31:0] cfgQ;
  logic [5:0]  swQ;
  wire  logic  wrCfg = psel & penable & pwrite & (paddr == crac_pkg::OFF_CFG);
  wire  logic  wrSw  = psel & penable & pwrite & (paddr == crac_pkg::OFF_SWCTRL);
  wire  logic [1:0] mode = cfgQ[1:0];
  // Lines only count when routed from the local source
  wire  logic  lineA = (cfgQ[6:4] == 3'h0) & (blockCtrlA | swQ[0]);
  wire  logic  lineB = (cfgQ[10:8] == 3'h0) & (blockCtrlB | swQ[1]);
  wire  logic  ldEff = loadData | swQ[2];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfgQ <= 32'h0000_0004;
      swQ  <= 6'h00;
    end
    else
    begin
      if (wrCfg)
        cfgQ <= pwdata;
      if (wrSw)
        swQ <= pwdata[5:0];
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // Chip reset pin must be idle for the sync latency before lines can be judged
  a_preset_one: assert property (chipResetN[*6] ##0 (mode == 2'h0 && lineA && !lineB) |-> storedBit)
    else $error("line A did not force a one");
  a_clear_zero: assert property ((mode inside {2'h0, 2'h1}) && lineB |-> !storedBit)
    else $error("line B did not clear the bit");
  a_lp_preset: assert property (mode == 2'h2 && lineB |-> storedBit)
    else $error("line B did not preset in load-with-preset");
  a_load_clear: assert property (chipResetN[*6] ##0 (mode[0] && lineA && !lineB) |-> storedBit == ldEff)
    else $error("asynchronous load gave wrong value");
  a_load_inv: assert property (chipResetN[*6] ##0 (mode == 2'h2 && lineA && !lineB) |-> storedBit == ldEff)
    else $error("inverted load gave wrong value");
  a_chip_reset: assert property ((!chipResetN)[*6] ##0 cfgQ[2] |-> storedBit == (mode == 2'h2) && !pinOut)
    else $error("chip reset did not override");
  a_ded_data: assert property (($stable(dedIn))[*6] |-> dedData == dedIn)
    else $error("dedicated data does not follow pins");
  a_pin_dir: assert property ((cfgQ[17:16] inside {2'h0, 2'h1}) |-> pinOe == cfgQ[16])
    else $error("pin enable wrong for direction");
  a_pin_out: assert property (chipResetN[*6] ##0 (cfgQ[17:16] == 2'h1) |=> pinOut == $past(swQ[4]))
    else $error("pin register did not take output data");
  a_unmapped_err: assert property (psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08}) |-> pslverr)
    else $error("no error on unmapped address");

  c_lp_preset: cover property (mode == 2'h2 && lineB);
  c_chip_reset: cover property ((!chipResetN)[*6] ##0 cfgQ[2]);
  c_unmapped: cover property (psel && penable && pslverr);
endmodule

bind crac_cell_ctrl crac_cell_checker chk
(
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pslverr(pslverr), .dedIn(dedIn), .chipResetN(chipResetN), .blockCtrlA(blockCtrlA), .blockCtrlB(blockCtrlB),
  .loadData(loadData), .storedBit(storedBit), .dedData(dedData), .pinOut(pinOut), .pinOe(pinOe)
);

// file: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        clk, rstn, psel, penable, pwrite, chipResetN, blockCtrlA, blockCtrlB, loadData, cellData, pinIn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, storedBit, pinOut, pinOe, pinCellData, er;
  logic [5:0]  dedIn, dedData;
  int          miscompares, checks;

  crac_cell_ctrl dut
  (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dedIn(dedIn), .chipResetN(chipResetN),
    .blockCtrlA(blockCtrlA), .blockCtrlB(blockCtrlB), .loadData(loadData), .cellData(cellData),
    .storedBit(storedBit), .dedData(dedData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pinCellData(pinCellData)
  );

  always #10 clk = ~clk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task complete_run;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Bus and line drivers
  // ------------------------------------------------------------
  // Answer and read data are taken only at the edge that sees pready high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
    begin
      miscompares++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdChk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd & mask, exp);
  endtask

  task chkBit(input logic exp);
    #1;
    check({31'h0, storedBit}, {31'h0, exp});
  endtask

  // No clock edge passes between driving the lines and looking
  task drive(input logic a, input logic b, input logic ld, input logic exp);
    @(posedge clk);
    blockCtrlA <= a;
    blockCtrlB <= b;
    loadData <= ld;
    #2;
    check({31'h0, storedBit}, {31'h0, exp});
  endtask

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    {psel, penable, pwrite, blockCtrlA, blockCtrlB, loadData, cellData, pinIn} = 8'h00;
    chipResetN = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    dedIn = 6'h00;
    miscompares = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rdChk(crac_pkg::OFF_CFG, 32'hFFFF_FFFF, 32'h0000_0004);
    rdChk(crac_pkg::OFF_SWCTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdChk(crac_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test reset values done");
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, crac_pkg::OFF_CFG, 32'h0000_0004 | 32'(m));
      for (int ld = 0; ld < 2; ld++)
      begin
        drive(1'b1, 1'b0, ld[0], (m == 0) | ld[0]);
        if (m != 3)
        begin
          drive(1'b0, 1'b1, ld[0], m == 2);
          drive(1'b1, 1'b1, ld[0], m == 2);
        end
      end
    end
    blockCtrlA <= 1'b0;
    blockCtrlB <= 1'b0;
    $display("test line modes done");
    apb(1'b1, crac_pkg::OFF_CFG, 32'h0000_0004);
    apb(1'b1, crac_pkg::OFF_SWCTRL, 32'h0000_0001);
    chkBit(1'b1);
    apb(1'b1, crac_pkg::OFF_SWCTRL, 32'h0000_0003);
    chkBit(1'b0);
    rdChk(crac_pkg::OFF_SWCTRL, 32'hFFFF_FFFF, 32'h0000_0003);
    rdChk(crac_pkg::OFF_STATUS, 32'h0000_000F, 32'h0000_0000);
    apb(1'b1, crac_pkg::OFF_SWCTRL, 32'h0000_0000);
    $display("test software lines done");
    blockCtrlA <= 1'b1;
    chipResetN <= 1'b0;
    repeat (7) @(posedge clk);
    chkBit(1'b0);
    rdChk(crac_pkg::OFF_STATUS, 32'h0000_0009, 32'h0000_0008);
    apb(1'b1, crac_pkg::OFF_CFG, 32'h0000_0006);
    chkBit(1'b1);
    chipResetN <= 1'b1;
    blockCtrlA <= 1'b0;
    repeat (7) @(posedge clk);
    $display("test chip reset done");
    dedIn <= 6'h2A;
    pinIn <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check({26'h0, dedData}, 32'h0000_002A);
    check({31'h0, pinCellData}, 32'h0000_0001);
    rdChk(crac_pkg::OFF_STATUS, 32'h0000_3F02, 32'h0000_2A02);
    cellData <= 1'b1;
    apb(1'b1, crac_pkg::OFF_CFG, 32'h0000_0104);
    @(posedge clk);
    chkBit(1'b1);
    dedIn <= 6'h2B;
    repeat (8) @(posedge clk);
    chkBit(1'b0);
    // Clock enable from dedicated input 0: the bit follows while it is high, holds once low
    apb(1'b1, crac_pkg::OFF_CFG, 32'h0000_1004);
    @(posedge clk);
    chkBit(1'b1);
    apb(1'b1, crac_pkg::OFF_SWCTRL, 32'h0000_0008);
    dedIn <= 6'h2A;
    @(posedge clk);
    chkBit(1'b0);
    repeat (6) @(posedge clk);
    apb(1'b1, crac_pkg::OFF_SWCTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chkBit(1'b0);
    $display("test dedicated inputs done");
    apb(1'b1, crac_pkg::OFF_CFG, 32'h0001_0004);
    apb(1'b1, crac_pkg::OFF_SWCTRL, 32'h0000_0010);
    repeat (2) @(posedge clk);
    #1;
    check({30'h0, pinOe, pinOut}, 32'h0000_0003);
    rdChk(crac_pkg::OFF_STATUS, 32'h0000_0006, 32'h0000_0006);
    apb(1'b1, crac_pkg::OFF_CFG, 32'h0002_0004);
    apb(1'b1, crac_pkg::OFF_SWCTRL, 32'h0000_0030);
    #1;
    check({31'h0, pinOe}, 32'h0000_0001);
    apb(1'b1, crac_pkg::OFF_SWCTRL, 32'h0000_0000);
    #1;
    check({31'h0, pinOe}, 32'h0000_0000);
    @(posedge clk);
    #1;
    check({30'h0, pinOut, pinCellData}, 32'h0000_0001);
    $display("test pin cell done");
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    check({31'h0, er}, 32'h0000_0001);
    rdChk(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
    check({31'h0, er}, 32'h0000_0001);
    rdChk(crac_pkg::OFF_CFG, 32'hFFFF_FFFF, 32'h0002_0004);
    $display("test unmapped access done");
    complete_run();
  end
endmodule
